// file: pkg/sbd_pkg.sv
// Functional notes
// (R1) One 64-bit data path shared by all agents
// (R2) Driver asserts data_valid_n on each valid transfer
// (R3) Four data values per common bus clock
// (R4) Receiver latches on both strobe falling edges
// (R5) Four 16-bit groups, each with strobe pair
// (R6) Active inversion flag means group sampled active-high
// (R7) Inversion flag driven with its inverted data
// (R8) Invert group when over half bits low
// (R9) Flag n governs lines 16n+15 down to 16n
// (R10) Driver holds data_bus_in_use_n while owning bus
// (R11) Bus free only after data_bus_in_use_n deasserts
// (R12) Addressed agent asserts order_deferral_n to processor
// (R13) Driver drives four parity lines with data
// (R14) data_valid_n may deassert for idle clocks
// (R15) Even parity per group over driven levels
// (R16) Receiver flags parity mismatch as data error
package sbd_pkg;

  localparam int DATA_W    = 64;
  localparam int GROUPS    = 4;
  localparam int GROUP_W   = 16;
  localparam int SUBPHASES = 4;
  localparam int ONES_W    = 5;

  // Sub-phase length; four of them must fit a 125 ns bus clock
  localparam int CORE_PERIOD_NS = 10;
  localparam int SUBPHASE_NS    = 30;
  localparam int SUBPHASE_CYC   = (SUBPHASE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  localparam logic [1:0] CYC_FIRST = 2'h0;
  localparam logic [1:0] CYC_LAST  = 2'(SUBPHASE_CYC - 1);
  localparam logic [1:0] SP_FIRST  = 2'h0;
  localparam logic [1:0] SP_LAST   = 2'(SUBPHASES - 1);
  localparam logic [1:0] CNT_STEP  = 2'h1;

  localparam logic [ONES_W-1:0] INV_THRESHOLD = ONES_W'(GROUP_W / 2);

  typedef logic [SUBPHASES-1:0][DATA_W-1:0] sbd_word_type;

  // Electrical pin levels; lines are active low except data lines of flagged groups, idle high
  typedef struct packed {
    logic [DATA_W-1:0] data_lines;
    logic [GROUPS-1:0] group_inversion_flags;
    logic [GROUPS-1:0] data_parity_lines;
    logic [GROUPS-1:0] strobe_pos_pair;
    logic [GROUPS-1:0] strobe_neg_pair;
    logic              data_valid_n;
    logic              data_bus_in_use_n;
  } sbd_pins_type;

  localparam sbd_pins_type PINS_IDLE = '1;
  localparam sbd_pins_type PINS_OFF  = '0;

  typedef struct packed {
    logic               par;
    logic               inv_n;
    logic [GROUP_W-1:0] line;
  } sbd_enc_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SEND = 3'h2,
    ST_GAP  = 3'h4
  } sbd_state_type;

  function automatic sbd_enc_type sbd_encode(input logic [GROUP_W-1:0] d);
    logic [ONES_W-1:0] ones;
    sbd_enc_type       enc;
    ones = '0;
    for (int i = 0; i < GROUP_W; i++) begin
      ones = ones + ONES_W'(d[i]);
    end
    // (R8) Invert on majority low
    enc.inv_n = ~(ones > INV_THRESHOLD);
    // (R7) Flag follows data form
    enc.line  = enc.inv_n ? ~d : d;
    // (R15) Even parity on lines
    enc.par   = ^enc.line;
    return enc;
  endfunction : sbd_encode

endpackage : sbd_pkg

// file: pkg/sbd_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sbd_bus_if (
  input wire logic bus_clk
);
  sbd_pkg::sbd_pins_type cpu_out;
  sbd_pkg::sbd_pins_type cpu_oe;
  sbd_pkg::sbd_pins_type cs_out;
  sbd_pkg::sbd_pins_type cs_oe;
  sbd_pkg::sbd_pins_type lines;
  logic                  order_deferral_n;

  // Pulled-up shared lines; any enabled low driver wins
  assign lines = sbd_pkg::sbd_pins_type'((cpu_out | ~cpu_oe) & (cs_out | ~cs_oe));

  modport cpu_mp (input bus_clk, input lines, input order_deferral_n,
                  output cpu_out, output cpu_oe);
  modport cs_mp (input bus_clk, input lines,
                 output cs_out, output cs_oe, output order_deferral_n);
endinterface : sbd_bus_if
`default_nettype wire

// file: rtl/sbd_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
module sbd_data_engine (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  bus_clk,
  input  wire sbd_pkg::sbd_pins_type pins_in,
  output var  sbd_pkg::sbd_pins_type pins_out,
  output var  sbd_pkg::sbd_pins_type pins_oe,
  input  wire logic                  tx_valid,
  input  wire sbd_pkg::sbd_word_type tx_data,
  input  wire logic                  tx_last,
  output logic                       tx_ready,
  output logic                       rx_valid,
  output sbd_pkg::sbd_word_type      rx_data,
  output logic                       rx_parity_err,
  output logic                       bus_free
);
  localparam int DW = sbd_pkg::DATA_W;
  localparam int GN = sbd_pkg::GROUPS;
  localparam int GW = sbd_pkg::GROUP_W;
  localparam int SN = sbd_pkg::SUBPHASES;

  sbd_pkg::sbd_pins_type pins_s1;
  sbd_pkg::sbd_pins_type pins_s2;
  sbd_pkg::sbd_pins_type pins_s3;
  logic                  bclk_s1;
  logic                  bclk_s2;
  logic                  bclk_s3;
  logic                  bclk_rise;
  sbd_pkg::sbd_state_type state;
  logic [1:0]            cyc;
  logic [1:0]            sp;
  sbd_pkg::sbd_word_type word;
  logic                  sent_last;
  logic                  own;
  logic                  load;
  logic                  phase_start;
  logic [DW-1:0]         drv_data;
  logic [GN-1:0]         drv_inv;
  logic [GN-1:0]         drv_par;
  logic [GN-1:0]         drv_pos;
  logic [GN-1:0]         drv_neg;
  logic                  drv_valid_n;
  logic                  drv_busy_n;
  logic                  drv_oe;
  logic                  rx_on;
  logic [GN-1:0]         pos_second;
  logic [GN-1:0]         neg_second;
  logic [GN-1:0]         grp_err;
  logic                  word_done;
  logic [GN-1:0][SN-1:0][GW-1:0] rx_grp;

  // Pins and bus clock come from outside this clock domain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1 <= sbd_pkg::PINS_IDLE;
      pins_s2 <= sbd_pkg::PINS_IDLE;
      pins_s3 <= sbd_pkg::PINS_IDLE;
    end else begin
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Reset high so a bus clock already high gives no false rise
      bclk_s1 <= 1'b1;
      bclk_s2 <= 1'b1;
      bclk_s3 <= 1'b1;
    end else begin
      bclk_s1 <= bus_clk;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
    end
  end

  assign bclk_rise   = bclk_s2 & ~bclk_s3;
  assign own         = (state != sbd_pkg::ST_IDLE);
  // (R11) Free only once busy line is high
  assign bus_free    = pins_s2.data_bus_in_use_n & ~own & drv_busy_n;
  // (R14) No word at the edge gives an idle clock
  assign tx_ready    = bclk_rise & (((state == sbd_pkg::ST_IDLE) & bus_free) |
                                    ((state == sbd_pkg::ST_GAP) & ~sent_last));
  assign load        = tx_valid & tx_ready;
  assign phase_start = (state == sbd_pkg::ST_SEND) & (cyc == sbd_pkg::CYC_FIRST);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sbd_pkg::ST_IDLE;
    end else begin
      case (state)
        sbd_pkg::ST_IDLE: begin
          if (load) begin
            state <= sbd_pkg::ST_SEND;
          end
        end
        sbd_pkg::ST_SEND: begin
          if (cyc == sbd_pkg::CYC_LAST && sp == sbd_pkg::SP_LAST) begin
            state <= sbd_pkg::ST_GAP;
          end
        end
        sbd_pkg::ST_GAP: begin
          if (load) begin
            state <= sbd_pkg::ST_SEND;
          end else if (bclk_rise && sent_last) begin
            state <= sbd_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= sbd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // (R3) Four sub-phases within one bus clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= sbd_pkg::CYC_FIRST;
      sp  <= sbd_pkg::SP_FIRST;
    end else if (load) begin
      cyc <= sbd_pkg::CYC_FIRST;
      sp  <= sbd_pkg::SP_FIRST;
    end else if (state == sbd_pkg::ST_SEND) begin
      if (cyc == sbd_pkg::CYC_LAST) begin
        cyc <= sbd_pkg::CYC_FIRST;
        sp  <= sp + sbd_pkg::CNT_STEP;
      end else begin
        cyc <= cyc + sbd_pkg::CNT_STEP;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word      <= '0;
      sent_last <= 1'b0;
    end else if (load) begin
      word      <= tx_data;
      sent_last <= tx_last;
    end
  end

  // Strobes fall one cycle after data settles, so capture sees stable data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_pos     <= '1;
      drv_neg     <= '1;
      drv_valid_n <= 1'b1;
      drv_busy_n  <= 1'b1;
      drv_oe      <= 1'b0;
    end else begin
      // (R4) Pos strobe even, neg odd
      drv_pos     <= {GN{~((state == sbd_pkg::ST_SEND) & (cyc != sbd_pkg::CYC_FIRST) & ~sp[0])}};
      drv_neg     <= {GN{~((state == sbd_pkg::ST_SEND) & (cyc != sbd_pkg::CYC_FIRST) & sp[0])}};
      // (R2) Valid low while sending
      drv_valid_n <= (state != sbd_pkg::ST_SEND);
      // (R10) Busy held while owning
      drv_busy_n  <= ~own;
      drv_oe      <= own;
    end
  end

  // Receive only what another agent drives
  assign rx_on = ~drv_oe & ~pins_s2.data_valid_n;

  // (R5) Per group strobe, flag, parity
  for (genvar g = 0; g < GN; g++) begin : g_grp
    sbd_pkg::sbd_enc_type enc;
    logic                 pos_fall;
    logic                 neg_fall;
    logic [GW-1:0]        line;
    logic [GW-1:0]        value;
    logic                 bad;

    // (R9) Group g owns lines 16g+15..16g
    assign enc      = sbd_pkg::sbd_encode(word[sp][g*GW +: GW]);
    assign line     = pins_s2.data_lines[g*GW +: GW];
    // (R6) Active flag means active-high
    assign value    = pins_s2.group_inversion_flags[g] ? ~line : line;
    // (R16) Parity mismatch check
    assign bad      = ^{pins_s2.data_parity_lines[g], line};
    assign pos_fall = pins_s3.strobe_pos_pair[g] & ~pins_s2.strobe_pos_pair[g] & rx_on;
    assign neg_fall = pins_s3.strobe_neg_pair[g] & ~pins_s2.strobe_neg_pair[g] & rx_on;

    // (R13) Parity driven with data
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        drv_data[g*GW +: GW] <= '1;
        drv_inv[g]           <= 1'b1;
        drv_par[g]           <= 1'b1;
      end else if (phase_start) begin
        drv_data[g*GW +: GW] <= enc.line;
        drv_inv[g]           <= enc.inv_n;
        drv_par[g]           <= enc.par;
      end
    end

    // (R4) Capture on both strobe falls
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        pos_second[g] <= 1'b0;
        neg_second[g] <= 1'b0;
        rx_grp[g]     <= '0;
      end else if (pins_s2.data_valid_n) begin
        pos_second[g] <= 1'b0;
        neg_second[g] <= 1'b0;
      end else begin
        if (pos_fall) begin
          rx_grp[g][{pos_second[g], 1'b0}] <= value;
          pos_second[g]                    <= ~pos_second[g];
        end
        if (neg_fall) begin
          rx_grp[g][{neg_second[g], 1'b1}] <= value;
          neg_second[g]                    <= ~neg_second[g];
        end
      end
    end

    // An error in the delivery cycle still counts: set beats clear
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        grp_err[g] <= 1'b0;
      end else if ((pos_fall | neg_fall) & bad) begin
        grp_err[g] <= 1'b1;
      end else if (word_done | pins_s2.data_valid_n) begin
        // Dropped partial words leave no stale error behind
        grp_err[g] <= 1'b0;
      end
    end

    for (genvar s = 0; s < SN; s++) begin : g_sp
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rx_data[s][g*GW +: GW] <= '0;
        end else if (word_done) begin
          rx_data[s][g*GW +: GW] <= rx_grp[g][s];
        end
      end
    end
  end

  // Word ends at the second negative strobe fall of group 0
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_done     <= 1'b0;
      rx_valid      <= 1'b0;
      rx_parity_err <= 1'b0;
    end else begin
      word_done     <= g_grp[0].neg_fall & neg_second[0];
      rx_valid      <= word_done;
      rx_parity_err <= word_done & (|grp_err);
    end
  end

  // (R1) All agents share these lines
  assign pins_out = '{data_lines:            drv_data,
                      group_inversion_flags: drv_inv,
                      data_parity_lines:     drv_par,
                      strobe_pos_pair:       drv_pos,
                      strobe_neg_pair:       drv_neg,
                      data_valid_n:          drv_valid_n,
                      data_bus_in_use_n:     drv_busy_n};
  assign pins_oe  = drv_oe ? sbd_pkg::PINS_IDLE : sbd_pkg::PINS_OFF;
endmodule : sbd_data_engine

module sbd_cpu_end (
  sbd_bus_if.cpu_mp                  bus,
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  tx_valid,
  input  wire sbd_pkg::sbd_word_type tx_data,
  input  wire logic                  tx_last,
  output logic                       tx_ready,
  output logic                       rx_valid,
  output sbd_pkg::sbd_word_type      rx_data,
  output logic                       rx_parity_err,
  output logic                       bus_free,
  output logic                       deferred
);
  logic order_deferral_n_s1;
  logic order_deferral_n_s2;

  sbd_data_engine u_engine (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .bus_clk       (bus.bus_clk),
    .pins_in       (bus.lines),
    .pins_out      (bus.cpu_out),
    .pins_oe       (bus.cpu_oe),
    .tx_valid      (tx_valid),
    .tx_data       (tx_data),
    .tx_last       (tx_last),
    .tx_ready      (tx_ready),
    .rx_valid      (rx_valid),
    .rx_data       (rx_data),
    .rx_parity_err (rx_parity_err),
    .bus_free      (bus_free)
  );

  // (R12) Deferral is an input here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      order_deferral_n_s1 <= 1'b1;
      order_deferral_n_s2 <= 1'b1;
    end else begin
      order_deferral_n_s1 <= bus.order_deferral_n;
      order_deferral_n_s2 <= order_deferral_n_s1;
    end
  end

  assign deferred = ~order_deferral_n_s2;
endmodule : sbd_cpu_end
`default_nettype wire

// file: rtl/sbd_agent_end.sv
`timescale 1ns/1ps
`default_nettype none
module sbd_agent_end (
  sbd_bus_if.cs_mp                   bus,
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  tx_valid,
  input  wire sbd_pkg::sbd_word_type tx_data,
  input  wire logic                  tx_last,
  output logic                       tx_ready,
  output logic                       rx_valid,
  output sbd_pkg::sbd_word_type      rx_data,
  output logic                       rx_parity_err,
  output logic                       bus_free,
  input  wire logic                  order_deferral_n_req
);
  logic order_deferral_n_n;

  sbd_data_engine u_engine (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .bus_clk       (bus.bus_clk),
    .pins_in       (bus.lines),
    .pins_out      (bus.cs_out),
    .pins_oe       (bus.cs_oe),
    .tx_valid      (tx_valid),
    .tx_data       (tx_data),
    .tx_last       (tx_last),
    .tx_ready      (tx_ready),
    .rx_valid      (rx_valid),
    .rx_data       (rx_data),
    .rx_parity_err (rx_parity_err),
    .bus_free      (bus_free)
  );

  // (R12) Assert deferral when order not guaranteed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      order_deferral_n_n <= 1'b1;
    end else begin
      order_deferral_n_n <= ~order_deferral_n_req;
    end
  end

  assign bus.order_deferral_n = order_deferral_n_n;
endmodule : sbd_agent_end
`default_nettype wire

// file: bench/sbd_bus_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sbd_bus_checker (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire sbd_pkg::sbd_pins_type lines,
  input wire sbd_pkg::sbd_pins_type cpu_oe,
  input wire sbd_pkg::sbd_pins_type cs_oe,
  input wire logic                  order_deferral_n
);
  logic [4:0] low_cnt;
  logic [2:0] fall_cnt;
  logic       pos_q;
  logic       neg_q;
  logic       edge_seen;
  logic [3:0] par_ok;
  logic [3:0] inv_ok;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Group 0 stands for all; a_groups_together keeps the rest aligned
  assign edge_seen = (pos_q & ~lines.strobe_pos_pair[0]) | (neg_q & ~lines.strobe_neg_pair[0]);

  always_comb begin
    int ones;
    ones = 0;
    for (int g = 0; g < 4; g++) begin
      ones = $countones(lines.data_lines[16*g +: 16]);
      par_ok[g] = ~^{lines.data_lines[16*g +: 16], lines.data_parity_lines[g]};
      inv_ok[g] = lines.group_inversion_flags[g] ? (ones >= 8) : (ones > 8);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 1'b1;
      neg_q <= 1'b1;
    end else begin
      pos_q <= lines.strobe_pos_pair[0];
      neg_q <= lines.strobe_neg_pair[0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 5'h0;
    end else if (lines.data_valid_n) begin
      low_cnt <= 5'h0;
    end else begin
      low_cnt <= low_cnt + 5'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt <= 3'h0;
    end else if (lines.data_valid_n) begin
      fall_cnt <= 3'h0;
    end else if (edge_seen) begin
      fall_cnt <= fall_cnt + 3'h1;
    end
  end

  a_full_width: assert property (
    !lines.data_valid_n |-> (&cpu_oe.data_lines) || (&cs_oe.data_lines))
    else $error("data valid without a full-width driver");
  a_one_owner: assert property (!((|cpu_oe) && (|cs_oe)))
    else $error("both ends drive the shared lines");
  a_valid_has_busy: assert property (!lines.data_valid_n |-> !lines.data_bus_in_use_n)
    else $error("data valid while bus not marked in use");
  a_valid_len: assert property ($rose(lines.data_valid_n) |-> low_cnt == 5'hc)
    else $error("data valid low span not twelve cycles");
  a_four_falls: assert property ($rose(lines.data_valid_n) |-> fall_cnt == 3'h4)
    else $error("word did not carry four strobe falls");
  a_fall_in_valid: assert property (
    edge_seen |-> !lines.data_valid_n && $stable(lines.data_lines))
    else $error("strobe fell outside valid or on moving data");
  a_groups_together: assert property (
    !lines.data_valid_n |-> lines.strobe_pos_pair inside {4'h0, 4'hf}
                            && lines.strobe_neg_pair inside {4'h0, 4'hf})
    else $error("group strobes out of step");
  a_parity_even: assert property (edge_seen |-> &par_ok)
    else $error("parity line wrong at strobe");
  a_inv_majority: assert property (edge_seen |-> &inv_ok)
    else $error("inversion flag disagrees with line levels");
  a_release_quiet: assert property ($rose(lines.data_bus_in_use_n) |-> lines.data_valid_n)
    else $error("bus released with data still valid");

  c_word_done: cover property ($rose(lines.data_valid_n));
  c_idle_clock: cover property (!lines.data_bus_in_use_n && lines.data_valid_n ##1 !lines.data_valid_n);
  c_cpu_release: cover property ($fell(|cpu_oe));
  c_deferral: cover property (!order_deferral_n);
endmodule : sbd_bus_checker
`default_nettype wire

// file: bench/system_bus_data_phase_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module system_bus_data_phase_tb;
  typedef struct {int d; sbd_pkg::sbd_word_type w; logic last;} sbd_row_type;
  logic                  core_clk;
  logic                  rst_n;
  logic                  bus_clk;
  logic                  order_deferral_n_req;
  wire                   deferred;
  logic [1:0]            txv;
  logic [1:0]            txl;
  sbd_pkg::sbd_word_type txd [2];
  wire  [1:0]            txr;
  wire  [1:0]            rxv;
  wire  [1:0]            rxe;
  wire  [1:0]            free;
  sbd_pkg::sbd_word_type rxd [2];
  wire                   rxv2;
  wire                   rxe2;
  sbd_pkg::sbd_word_type rxd2;
  sbd_pkg::sbd_pins_type cap [$];
  sbd_row_type           rows [6];
  int                    fail_count;
  int                    cmp_count;

  sbd_bus_if bus (.bus_clk(bus_clk));
  sbd_bus_if bus2 (.bus_clk(bus_clk));
  sbd_cpu_end sbd_cpu_end_inst (.bus(bus.cpu_mp), .core_clk(core_clk), .rst_n(rst_n),
    .tx_valid(txv[0]), .tx_data(txd[0]), .tx_last(txl[0]), .tx_ready(txr[0]), .rx_valid(rxv[0]),
    .rx_data(rxd[0]), .rx_parity_err(rxe[0]), .bus_free(free[0]), .deferred(deferred));
  sbd_agent_end sbd_agent_end_inst (.bus(bus.cs_mp), .core_clk(core_clk), .rst_n(rst_n),
    .tx_valid(txv[1]), .tx_data(txd[1]), .tx_last(txl[1]), .tx_ready(txr[1]), .rx_valid(rxv[1]),
    .rx_data(rxd[1]), .rx_parity_err(rxe[1]), .bus_free(free[1]), .order_deferral_n_req(order_deferral_n_req));
  // Second end faces a bench driver that breaks parity
  sbd_cpu_end sbd_cpu_end_inst2 (.bus(bus2.cpu_mp), .core_clk(core_clk), .rst_n(rst_n),
    .tx_valid(1'b0), .tx_data('0), .tx_last(1'b0), .tx_ready(), .rx_valid(rxv2),
    .rx_data(rxd2), .rx_parity_err(rxe2), .bus_free(), .deferred());
  sbd_bus_checker sbd_bus_checker_inst (.core_clk(core_clk), .rst_n(rst_n), .lines(bus.lines),
    .cpu_oe(bus.cpu_oe), .cs_oe(bus.cs_oe), .order_deferral_n(bus.order_deferral_n));

  always #5 core_clk = ~core_clk;
  always #62.5 bus_clk = ~bus_clk;

  always @(negedge bus.lines.strobe_pos_pair[0] or negedge bus.lines.strobe_neg_pair[0]) begin
    if (rst_n === 1'b1) begin
      cap.push_back(bus.lines);
    end
  end

  function automatic logic [17:0] enc(input logic [15:0] d);
    logic [15:0] l;
    l = ($countones(d) > 8) ? d : ~d;
    return {^l, !($countones(d) > 8), l};
  endfunction : enc

  // Majority boundaries 7, 8, 9 ones spread over groups and sub-phases
  function automatic sbd_pkg::sbd_word_type mk(input int k);
    logic [15:0] pat [8];
    pat = '{16'h0000, 16'hffff, 16'h00ff, 16'h01ff, 16'hfe00, 16'h8001, 16'h7fff, 16'ha5a5};
    for (int s = 0; s < 4; s++) begin
      for (int g = 0; g < 4; g++) begin
        mk[s][16*g +: 16] = pat[(k + 3*s + g) % 8];
      end
    end
  endfunction : mk

  task automatic send(input int d, input sbd_pkg::sbd_word_type w, input logic last);
    int n;
    n = 0;
    @(posedge core_clk);
    txv[d] <= 1'b1;
    txd[d] <= w;
    txl[d] <= last;
    do @(negedge core_clk); while (txr[d] !== 1'b1 && ++n < 400);
    `CHK(txr[d], 1'b1)
    @(posedge core_clk);
    txv[d] <= 1'b0;
    repeat (5) @(negedge core_clk);
    `CHK(free[1-d], 1'b0)
  endtask : send

  task automatic chk_wire(input sbd_pkg::sbd_word_type w);
    sbd_pkg::sbd_pins_type p;
    `CHK(cap.size(), 4)
    for (int s = 0; s < 4 && s < cap.size(); s++) begin
      p = cap[s];
      `CHK({p.data_valid_n, p.data_bus_in_use_n}, 2'b00)
      for (int g = 0; g < 4; g++) begin
        `CHK({p.data_parity_lines[g], p.group_inversion_flags[g], p.data_lines[16*g +: 16]}, enc(w[s][16*g +: 16]))
      end
    end
    cap.delete();
  endtask : chk_wire

  task automatic recv(input int d, input sbd_pkg::sbd_word_type w);
    int n;
    n = 0;
    do @(negedge core_clk); while (rxv[d] !== 1'b1 && ++n < 400);
    `CHK(rxv[d], 1'b1)
    `CHK(rxd[d], w)
    `CHK(rxe[d], 1'b0)
    chk_wire(w);
  endtask : recv

  task automatic bad_word(input sbd_pkg::sbd_word_type w);
    sbd_pkg::sbd_pins_type p;
    int                    n;
    p = sbd_pkg::PINS_IDLE;
    p.data_valid_n = 1'b0;
    p.data_bus_in_use_n = 1'b0;
    for (int s = 0; s < 4; s++) begin
      for (int g = 0; g < 4; g++) begin
        {p.data_parity_lines[g], p.group_inversion_flags[g], p.data_lines[16*g +: 16]} = enc(w[s][16*g +: 16]);
      end
      if (s == 2) begin
        p.data_parity_lines[1] = ~p.data_parity_lines[1];
      end
      @(posedge core_clk);
      bus2.cs_out <= p;
      bus2.cs_oe <= '1;
      if (s % 2 == 1) p.strobe_neg_pair = 4'h0;
      else p.strobe_pos_pair = 4'h0;
      @(posedge core_clk);
      bus2.cs_out <= p;
      repeat (2) @(posedge core_clk);
      p.strobe_pos_pair = 4'hf;
      p.strobe_neg_pair = 4'hf;
    end
    p.data_valid_n = 1'b1;
    bus2.cs_out <= p;
    @(posedge core_clk);
    bus2.cs_out <= sbd_pkg::PINS_IDLE;
    bus2.cs_oe <= '0;
    n = 0;
    do @(negedge core_clk); while (rxv2 !== 1'b1 && ++n < 400);
    `CHK(rxv2, 1'b1)
    `CHK(rxe2, 1'b1)
    `CHK(rxd2, w)
  endtask : bad_word

  task automatic tally_and_finish();
    $display("Counts: fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    core_clk = 1'b0;
    bus_clk = 1'b0;
    rst_n = 1'b0;
    txv = 2'b00;
    txl = 2'b00;
    txd[0] = '0;
    txd[1] = '0;
    order_deferral_n_req = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    bus2.cs_out = sbd_pkg::PINS_IDLE;
    bus2.cs_oe = '0;
    bus2.order_deferral_n = 1'b1;
    rows[0] = '{0, mk(0), 1'b0};
    rows[1] = '{0, mk(1), 1'b1};
    rows[2] = '{1, mk(2), 1'b1};
    rows[3] = '{1, mk(3), 1'b0};
    rows[4] = '{1, mk(4), 1'b1};
    rows[5] = '{0, mk(5), 1'b1};
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    foreach (rows[r]) begin
      send(rows[r].d, rows[r].w, rows[r].last);
      recv(1 - rows[r].d, rows[r].w);
      if (rows[r].last) begin
        repeat (40) @(negedge core_clk);
        `CHK(free, 2'b11)
      end
    end
    bad_word(mk(6));
    @(posedge core_clk);
    order_deferral_n_req <= 1'b1;
    repeat (5) @(negedge core_clk);
    `CHK({bus.order_deferral_n, deferred}, 2'b01)
    @(posedge core_clk);
    rst_n <= 1'b0;
    order_deferral_n_req <= 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(bus.lines, sbd_pkg::PINS_IDLE)
    `CHK({deferred, rxv}, 3'h0)
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    send(1, mk(7), 1'b1);
    recv(0, mk(7));
    tally_and_finish();
  end
endmodule : system_bus_data_phase_tb
`default_nettype wire
